// >>> hdl/tscc_pkg.sv
package tscc_pkg;
    // ==========================================
    // Sizes
    localparam int NUM_CH = 16;
    localparam int IMP_W = 13;
    localparam int ACC_W = 16;
    localparam int CAL_SAMPLES = 8;
    localparam int CAL_SHIFT = 3;

    // ==========================================
    // Timing
    localparam int TICK_MS = 10;
    localparam int CLK_MHZ = 100;
    localparam int TICK_CYCLES_DOC = TICK_MS * 1000 * CLK_MHZ;

    // ==========================================
    // Register offsets and reset value
    localparam logic [7:0] ADDR_CH_EN_HI = 8'h73;
    localparam logic [7:0] ADDR_CAL_PERIOD = 8'h76;
    localparam logic [7:0] ADDR_CAL_CFG = 8'h77;
    localparam logic [7:0] ADDR_MF_CFG = 8'h78;
    localparam logic [7:0] ADDR_DATA_SEL = 8'h7c;
    localparam logic [7:0] RESET_VALUE = 8'h00;

    // ==========================================
    // Field positions
    localparam int INTERVAL_LSB = 0;
    localparam int INTERVAL_W = 6;
    localparam int MULT_LSB = 6;
    localparam int MULT_W = 2;
    localparam int CAL_EN_BIT = 0;
    localparam int MODEL_LSB = 1;
    localparam int MODEL_W = 2;
    localparam int SPACING_LSB = 3;
    localparam int SPACING_W = 5;
    localparam int MF_ON_BIT = 0;
    localparam int MF_KIND_LSB = 1;
    localparam int MF_KIND_W = 2;

    // ==========================================
    // Codes
    localparam logic [1:0] MODEL_AUTO = 2'h0;
    localparam logic [1:0] MODEL_AUTOTUNE = 2'h2;
    localparam logic [7:0] SEL_TOUCH_TH = 8'h01;
    localparam logic [7:0] SEL_ENV_TH = 8'h02;
    localparam logic [7:0] SEL_DELAY = 8'h03;
    localparam logic [7:0] SEL_LIVE = 8'h04;
    localparam logic [7:0] SEL_REF = 8'h05;
    localparam logic [7:0] SEL_FROZEN = 8'h06;
    localparam logic [3:0] WIDTH_THRESH = 4'h9;
    localparam logic [3:0] WIDTH_DELAY = 4'h6;
    localparam logic [3:0] WIDTH_IMP = 4'hd;
    localparam logic [3:0] WIDTH_NONE = 4'h0;

    // Multiplier codes 0..3 give 8, 32, 128, 512: a shift of 3 plus 2 per step
    localparam int MULT_BASE_SHIFT = 3;
    localparam int MULT_STEP_SHIFT = 2;

    function automatic logic [15:0] period_ticks(input logic [5:0] interval, input logic [1:0] mult);
        return 16'({10'h000, interval} << (MULT_BASE_SHIFT + MULT_STEP_SHIFT * int'(mult)));
    endfunction : period_ticks
endpackage : tscc_pkg

// >>> hdl/tscc_cal_seq.sv
`timescale 1ns/10ps
module tscc_cal_seq #(
    parameter int TICK_CYCLES = tscc_pkg::TICK_CYCLES_DOC
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic cal_enable,
    input wire logic [5:0] interval,
    input wire logic [1:0] mult,
    input wire logic [4:0] spacing,
    output logic sample,
    output logic done
);
    import tscc_pkg::*;

    localparam int PW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
    localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYCLES - 1);

    if (TICK_CYCLES < 1) begin : g_chk
        $error("TICK_CYCLES must be at least 1");
    end

    typedef enum logic [1:0] {
        CS_IDLE = 2'b00,
        CS_WAIT = 2'b01,
        CS_SAMPLE = 2'b10
    } tscc_cal_state_t;

    typedef struct packed {
        tscc_cal_state_t state;
        logic [PW-1:0] pre;
        logic tick;
        logic [15:0] pc;
        logic [4:0] sc;
        logic [4:0] sp;
        logic [2:0] nsamp;
        logic sample;
        logic done;
    } tscc_cal_t;

    tscc_cal_t r;
    tscc_cal_t next_r;
    logic [15:0] target;
    logic [4:0] spacing_eff;

    assign target = period_ticks(interval, mult);
    // A zero spacing would fire every tick anyway; treat it as one tick
    assign spacing_eff = (spacing == 5'h00) ? 5'h01 : spacing;

    // ==========================================
    // Sequencer
    always_comb begin
        next_r = r;
        next_r.sample = 1'b0;
        next_r.done = 1'b0;
        next_r.tick = (r.pre == PRE_LAST);
        next_r.pre = next_r.tick ? '0 : r.pre + PW'(1);
        if (!cal_enable || interval == 6'h00) begin
            next_r.state = CS_IDLE;
            next_r.pc = 16'h0000;
            next_r.sc = 5'h00;
        end else if (r.tick) begin
            // Period runs free so expiries are spaced by the full period; one falling in an event is dropped
            next_r.pc = (r.pc + 16'h0001 >= target) ? 16'h0000 : r.pc + 16'h0001;
            case (r.state)
                CS_IDLE: begin
                    next_r.state = CS_WAIT;
                    next_r.pc = 16'h0000;
                end
                CS_WAIT: begin
                    if (r.pc + 16'h0001 >= target) begin
                        next_r.sample = 1'b1;
                        next_r.sc = 5'h00;
                        // Spacing is held for the whole event so a host write cannot bunch or stretch samples
                        next_r.sp = spacing_eff;
                        next_r.nsamp = 3'h0;
                        next_r.state = CS_SAMPLE;
                    end
                end
                CS_SAMPLE: begin
                    if (r.sc + 5'h01 >= r.sp) begin
                        next_r.sample = 1'b1;
                        next_r.sc = 5'h00;
                        next_r.nsamp = r.nsamp + 3'h1;
                        if (r.nsamp == 3'(CAL_SAMPLES - 2)) begin
                            next_r.done = 1'b1;
                            next_r.state = CS_WAIT;
                        end
                    end else begin
                        next_r.sc = r.sc + 5'h01;
                    end
                end
                default: next_r.state = CS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign sample = r.sample;
    assign done = r.done;

    // ==========================================
    // Checks
    logic [3:0] h_cnt;
    logic [15:0] h_gap;
    logic [4:0] h_sp_q;
    logic [4:0] h_sp;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            h_cnt <= 4'h0;
            h_gap <= 16'h0000;
            h_sp_q <= 5'h00;
            h_sp <= 5'h00;
        end else begin
            h_sp_q <= spacing_eff;
            if (r.sample) begin
                h_cnt <= (r.nsamp == 3'h0) ? 4'h1 : h_cnt + 4'h1;
                h_gap <= {15'h0000, r.tick};
                if (r.nsamp == 3'h0) begin
                    h_sp <= h_sp_q;
                end
            end else if (r.tick && h_gap != 16'hffff) begin
                h_gap <= h_gap + 16'h0001;
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    property p_eight_samples;
        done |=> h_cnt == 4'h8;
    endproperty
    a_eight_samples: assert property (p_eight_samples) else $error("calibration event not eight samples");

    property p_spacing;
        sample && $past(r.state) == CS_SAMPLE |-> h_gap == {11'h000, h_sp};
    endproperty
    a_spacing: assert property (p_spacing) else $error("sample spacing wrong");

    property p_suppress;
        !cal_enable ##1 !cal_enable |-> !sample && !done;
    endproperty
    a_suppress: assert property (p_suppress) else $error("calibration ran while disabled");
endmodule : tscc_cal_seq

// >>> hdl/tscc_top.sv
`timescale 1ns/10ps
// Summary of operation
// - Each bit of the upper channel enable register switches sensing channels 8 to 15 on when one, off when zero.
// - The calibration period is the six-bit interval times 10 ms times 8, 32, 128 or 512 from the two-bit code.
// - Calibration samples are spaced by the five-bit spacing field times 10 ms.
// - Model code 00 is plain auto calibration, 10 adds auto-tuning, and the host never writes 01 or 11.
// - In the auto-tuning model the host is denied access to each channel's reference delay.
// - In the auto-tuning model a channel drifting out of the dynamic range starts auto-tuning by itself.
// - The calibration enable bit turns periodic calibration on when one and suppresses it when zero.
// - The data select register decides which per-channel quantity the channel data registers present.
// - Select codes 1 to 6 mean touch and environment thresholds, delay, live, reference and frozen impedance.
// - Selecting frozen impedance takes one snapshot; another code and then frozen again takes a fresh one.
// - Each calibration event averages eight impedance samples into the calibrated reference.
module tscc_top #(
    parameter int TICK_CYCLES = tscc_pkg::TICK_CYCLES_DOC
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic [tscc_pkg::NUM_CH*tscc_pkg::IMP_W-1:0] live_impedance,
    input wire logic [tscc_pkg::NUM_CH-1:0] out_of_range,
    output logic [7:0] channel_enable_high,
    output logic calibration_enable,
    output logic delay_access_denied,
    output logic autotune_start,
    output logic median_filter_on,
    output logic [1:0] median_filter_kind,
    output logic [7:0] channel_data_select,
    output logic [3:0] channel_data_width,
    output logic freeze_capture,
    output logic calibration_update,
    output logic [tscc_pkg::NUM_CH*tscc_pkg::IMP_W-1:0] calibrated_reference
);
    import tscc_pkg::*;

    if (NUM_CH < 1 || IMP_W > ACC_W - CAL_SHIFT) begin : g_chk
        $error("accumulator too narrow for eight samples");
    end

    typedef struct packed {
        logic [7:0] ch_en;
        logic [7:0] period;
        logic [7:0] cfg;
        logic [7:0] mf;
        logic [7:0] dsel;
        logic rvalid;
        logic [7:0] rdata;
        logic deny;
        logic [3:0] width;
        logic freeze;
        logic tune_cond;
        logic tune;
        logic update;
        logic [NUM_CH-1:0][ACC_W-1:0] acc;
        logic [NUM_CH-1:0][IMP_W-1:0] ref_v;
    } tscc_state_t;

    tscc_state_t r;
    tscc_state_t next_r;
    logic cal_sample;
    logic cal_done;
    logic [NUM_CH-1:0][ACC_W-1:0] acc_sum;

    // ==========================================
    // Calibration timing
    tscc_cal_seq #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_cal_seq (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .cal_enable(r.cfg[CAL_EN_BIT]),
        .interval(r.period[INTERVAL_LSB +: INTERVAL_W]),
        .mult(r.period[MULT_LSB +: MULT_W]),
        .spacing(r.cfg[SPACING_LSB +: SPACING_W]),
        .sample(cal_sample),
        .done(cal_done)
    );

    // ==========================================
    // Per-channel running sum of calibration samples
    for (genvar i = 0; i < NUM_CH; i++) begin : g_acc
        assign acc_sum[i] = r.acc[i] + ACC_W'(live_impedance[i*IMP_W +: IMP_W]);
    end

    // ==========================================
    // Register file and derived state
    always_comb begin
        next_r = r;
        next_r.rvalid = reg_read;
        next_r.freeze = 1'b0;
        if (reg_read) begin
            case (reg_addr)
                ADDR_CH_EN_HI: next_r.rdata = r.ch_en;
                ADDR_CAL_PERIOD: next_r.rdata = r.period;
                ADDR_CAL_CFG: next_r.rdata = r.cfg;
                ADDR_MF_CFG: next_r.rdata = r.mf;
                ADDR_DATA_SEL: next_r.rdata = r.dsel;
                default: next_r.rdata = 8'h00;
            endcase
        end
        // Settings are taken at any time; keeping them still while sensing runs is the host's duty
        if (reg_write) begin
            case (reg_addr)
                ADDR_CH_EN_HI: next_r.ch_en = reg_wdata;
                ADDR_CAL_PERIOD: next_r.period = reg_wdata;
                ADDR_CAL_CFG: next_r.cfg = reg_wdata;
                ADDR_MF_CFG: next_r.mf = reg_wdata;
                ADDR_DATA_SEL: begin
                    next_r.dsel = reg_wdata;
                    // Only a change into the frozen code takes a new snapshot
                    next_r.freeze = (reg_wdata == SEL_FROZEN) && (r.dsel != SEL_FROZEN);
                end
                default: begin
                end
            endcase
        end
        // Reserved model codes behave as plain auto calibration
        next_r.deny = (next_r.cfg[MODEL_LSB +: MODEL_W] == MODEL_AUTOTUNE);
        case (next_r.dsel)
            SEL_TOUCH_TH: next_r.width = WIDTH_THRESH;
            SEL_ENV_TH: next_r.width = WIDTH_THRESH;
            SEL_DELAY: next_r.width = WIDTH_DELAY;
            SEL_LIVE: next_r.width = WIDTH_IMP;
            SEL_REF: next_r.width = WIDTH_IMP;
            SEL_FROZEN: next_r.width = WIDTH_IMP;
            default: next_r.width = WIDTH_NONE;
        endcase
        // Edge on the drift condition so a long drift asks for one tuning run only
        next_r.tune_cond = r.deny && (|out_of_range);
        next_r.tune = next_r.tune_cond && !r.tune_cond;
        next_r.update = cal_done;
        for (int i = 0; i < NUM_CH; i++) begin
            if (cal_done) begin
                next_r.ref_v[i] = IMP_W'(acc_sum[i] >> CAL_SHIFT);
                next_r.acc[i] = '0;
            end else if (!r.cfg[CAL_EN_BIT] || r.period[INTERVAL_LSB +: INTERVAL_W] == 6'h00) begin
                // An aborted event must not leave a partial sum for the next one
                next_r.acc[i] = '0;
            end else if (cal_sample) begin
                next_r.acc[i] = acc_sum[i];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign reg_rdata = r.rdata;
    assign reg_rvalid = r.rvalid;
    assign channel_enable_high = r.ch_en;
    assign calibration_enable = r.cfg[CAL_EN_BIT];
    assign delay_access_denied = r.deny;
    assign autotune_start = r.tune;
    assign median_filter_on = r.mf[MF_ON_BIT];
    assign median_filter_kind = r.mf[MF_KIND_LSB +: MF_KIND_W];
    assign channel_data_select = r.dsel;
    assign channel_data_width = r.width;
    assign freeze_capture = r.freeze;
    assign calibration_update = r.update;
    assign calibrated_reference = r.ref_v;

    // ==========================================
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    sequence s_frozen_write;
        reg_write && reg_addr == ADDR_DATA_SEL && reg_wdata == SEL_FROZEN && channel_data_select != SEL_FROZEN;
    endsequence

    sequence s_one_pulse;
        freeze_capture ##1 !freeze_capture;
    endsequence

    property p_freeze;
        s_frozen_write |=> s_one_pulse;
    endproperty
    a_freeze: assert property (p_freeze) else $error("snapshot not taken once");

    property p_no_refreeze;
        channel_data_select == SEL_FROZEN ##1 channel_data_select == SEL_FROZEN |-> !freeze_capture;
    endproperty
    a_no_refreeze: assert property (p_no_refreeze) else $error("snapshot refreshed while frozen");

    property p_chan_en;
        reg_write && reg_addr == ADDR_CH_EN_HI |=> channel_enable_high == $past(reg_wdata);
    endproperty
    a_chan_en: assert property (p_chan_en) else $error("channel enable not written");

    property p_deny;
        reg_write && reg_addr == ADDR_CAL_CFG |=>
            delay_access_denied == ($past(reg_wdata[MODEL_LSB +: MODEL_W]) == MODEL_AUTOTUNE);
    endproperty
    a_deny: assert property (p_deny) else $error("delay access state wrong");

    sequence s_drift_begins;
        delay_access_denied && (|out_of_range) && !$past(delay_access_denied && (|out_of_range));
    endsequence

    property p_tune;
        s_drift_begins |=> autotune_start ##1 !autotune_start;
    endproperty
    a_tune: assert property (p_tune) else $error("auto-tuning not started on drift");

    property p_read_sel;
        reg_read && reg_addr == ADDR_DATA_SEL |=> reg_rvalid && reg_rdata == $past(channel_data_select);
    endproperty
    a_read_sel: assert property (p_read_sel) else $error("data select readback wrong");

    property p_mf;
        reg_write && reg_addr == ADDR_MF_CFG |=> median_filter_on == $past(reg_wdata[MF_ON_BIT]);
    endproperty
    a_mf: assert property (p_mf) else $error("median filter enable wrong");

    property p_width;
        channel_data_select == SEL_DELAY |-> channel_data_width == WIDTH_DELAY;
    endproperty
    a_width: assert property (p_width) else $error("delay width wrong");

    property p_reset;
        $rose(rstn) |-> channel_enable_high == RESET_VALUE && channel_data_select == RESET_VALUE
            && !calibration_enable && !median_filter_on;
    endproperty
    a_reset: assert property (p_reset) else $error("registers not cleared by reset");
endmodule : tscc_top

// >>> bench/tscc_host_model.sv
`timescale 1ns/10ps
// ==========================================
// Host side of the byte register port
module tscc_host_model (
    input wire logic clk_sys,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_write,
    output logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
    end

    // Callers never send reserved model codes; the random register writes are made without first stopping calibration
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(negedge clk_sys);
        reg_write = 1'b0;
        // Idle lines flip so a stale byte is never mistaken for fresh data
        reg_wdata = ~d;
        reg_addr = ~a;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        @(negedge clk_sys);
        reg_addr = a;
        reg_read = 1'b1;
        @(negedge clk_sys);
        reg_read = 1'b0;
        ok = reg_rvalid;
        d = reg_rdata;
        reg_addr = ~a;
    endtask : rd
endmodule : tscc_host_model

// >>> bench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import tscc_pkg::*;
    localparam int TK = 2;
    logic clk_sys, rstn, reg_write, reg_read, reg_rvalid, calibration_enable, delay_access_denied;
    logic autotune_start, median_filter_on, freeze_capture, calibration_update;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, channel_enable_high, channel_data_select;
    logic [1:0] median_filter_kind;
    logic [3:0] channel_data_width;
    logic [NUM_CH*IMP_W-1:0] live_impedance, calibrated_reference;
    logic [NUM_CH-1:0] out_of_range;
    int error_cnt = 0;
    int checked = 0;

    tscc_top #(.TICK_CYCLES(TK)) i_tscc_top (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .live_impedance(live_impedance), .out_of_range(out_of_range),
        .channel_enable_high(channel_enable_high), .calibration_enable(calibration_enable),
        .delay_access_denied(delay_access_denied), .autotune_start(autotune_start),
        .median_filter_on(median_filter_on), .median_filter_kind(median_filter_kind),
        .channel_data_select(channel_data_select), .channel_data_width(channel_data_width),
        .freeze_capture(freeze_capture), .calibration_update(calibration_update),
        .calibrated_reference(calibrated_reference));
    tscc_host_model i_tscc_host_model (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    // ==========================================
    // Checking helpers
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic ok;
        i_tscc_host_model.rd(a, d, ok);
        chk("rvalid", 16'h0001, 16'(ok));
        chk(n, 16'(e), 16'(d));
    endtask : rchk

    task automatic finish_test();
        $display("Checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test

    function automatic logic [3:0] exp_width(input logic [7:0] c);
        case (c)
            8'h01, 8'h02: return WIDTH_THRESH;
            8'h03: return WIDTH_DELAY;
            8'h04, 8'h05, 8'h06: return WIDTH_IMP;
            default: return WIDTH_NONE;
        endcase
    endfunction : exp_width

    // Expiries that land inside a running event are skipped
    function automatic logic [15:0] exp_period(input logic [5:0] iv, input logic [1:0] m, input logic [4:0] sp);
        logic [15:0] p;
        logic [15:0] e;
        logic [15:0] l;
        p = 16'(iv) << (3 + 2 * m);
        l = 16'h0007 * ((sp == 5'h00) ? 16'h0001 : 16'(sp));
        e = p;
        while (e <= l) e += p;
        return e * TK;
    endfunction : exp_period

    task automatic cnt_pulse(input int cyc, input logic upd, output int n);
        n = 0;
        repeat (cyc) begin
            @(negedge clk_sys);
            if ((upd ? calibration_update : autotune_start) === 1'b1) n++;
        end
    endtask : cnt_pulse

    task automatic wait_upd(output int n);
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (calibration_update !== 1'b1 && n < 3000);
    endtask : wait_upd

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        error_cnt++;
        $display("[FAIL] watchdog expected done seen hang");
        finish_test();
    end

    // ==========================================
    // Main sequence
    initial begin
        logic [7:0] regs [5];
        logic [7:0] vals [5];
        logic [5:0] ivs [7];
        logic [1:0] mls [7];
        logic [4:0] sps [7];
        logic [7:0] v;
        int n;
        regs = '{ADDR_CH_EN_HI, ADDR_CAL_PERIOD, ADDR_CAL_CFG, ADDR_MF_CFG, ADDR_DATA_SEL};
        ivs = '{6'h01, 6'h01, 6'h01, 6'h03, 6'h01, 6'h01, 6'h01};
        mls = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h3};
        sps = '{5'h00, 5'h02, 5'h03, 5'h01, 5'h01, 5'h04, 5'h1f};
        rstn = 1'b0;
        out_of_range = '0;
        void'($urandom(32'h3389));
        for (int k = 0; k < NUM_CH; k++) live_impedance[k*IMP_W +: IMP_W] = 13'($urandom);
        repeat (10) @(negedge clk_sys);
        rstn = 1'b1;
        foreach (regs[i]) rchk("reset value", regs[i], RESET_VALUE);
        chk("reset outputs", 16'h0000, 16'({channel_enable_high, calibration_enable, median_filter_on}));
        repeat (6) begin
            foreach (regs[i]) begin
                v = 8'($urandom);
                if (regs[i] == ADDR_CAL_CFG) v[1] = 1'b0;
                vals[i] = v;
                i_tscc_host_model.wr(regs[i], v);
                rchk("readback", regs[i], v);
            end
            chk("channel_enable_high", 16'(vals[0]), 16'(channel_enable_high));
            chk("calibration_enable", 16'(vals[2][0]), 16'(calibration_enable));
            chk("delay_access_denied", 16'(vals[2][2:1] == MODEL_AUTOTUNE), 16'(delay_access_denied));
            chk("median_filter", 16'(vals[3][2:0]), 16'({median_filter_kind, median_filter_on}));
            chk("channel_data_select", 16'(vals[4]), 16'(channel_data_select));
        end
        i_tscc_host_model.wr(8'h74, 8'h5a);
        rchk("unmapped", 8'h74, 8'h00);
        chk("unmapped write", 16'(vals[0]), 16'(channel_enable_high));
        for (int c = 0; c < 8; c++) begin
            i_tscc_host_model.wr(ADDR_DATA_SEL, 8'(c));
            chk("channel_data_width", 16'(exp_width(8'(c))), 16'(channel_data_width));
        end
        i_tscc_host_model.wr(ADDR_DATA_SEL, 8'h00);
        i_tscc_host_model.wr(ADDR_DATA_SEL, SEL_FROZEN);
        chk("freeze first", 16'h0001, 16'(freeze_capture));
        i_tscc_host_model.wr(ADDR_DATA_SEL, SEL_FROZEN);
        chk("freeze repeat", 16'h0000, 16'(freeze_capture));
        i_tscc_host_model.wr(ADDR_DATA_SEL, SEL_REF);
        i_tscc_host_model.wr(ADDR_DATA_SEL, SEL_FROZEN);
        chk("freeze fresh", 16'h0001, 16'(freeze_capture));
        i_tscc_host_model.wr(ADDR_CAL_CFG, 8'h04);
        chk("delay_access_denied", 16'h0001, 16'(delay_access_denied));
        out_of_range[$urandom % NUM_CH] = 1'b1;
        cnt_pulse(4, 1'b0, n);
        chk("autotune start", 16'h0001, 16'(n));
        cnt_pulse(10, 1'b0, n);
        chk("autotune held drift", 16'h0000, 16'(n));
        out_of_range = '0;
        i_tscc_host_model.wr(ADDR_CAL_CFG, 8'h00);
        chk("delay_access_denied", 16'h0000, 16'(delay_access_denied));
        out_of_range = 16'hffff;
        cnt_pulse(6, 1'b0, n);
        chk("autotune plain model", 16'h0000, 16'(n));
        out_of_range = '0;
        foreach (ivs[i]) begin
            i_tscc_host_model.wr(ADDR_CAL_CFG, 8'h00);
            for (int k = 0; k < NUM_CH; k++) live_impedance[k*IMP_W +: IMP_W] = 13'($urandom);
            i_tscc_host_model.wr(ADDR_CAL_PERIOD, {mls[i], ivs[i]});
            i_tscc_host_model.wr(ADDR_CAL_CFG, {sps[i], 3'h1});
            wait_upd(n);
            chk("calibration_update", 16'h0001, 16'(calibration_update));
            for (int k = 0; k < NUM_CH; k++) begin
                chk("reference", 16'(live_impedance[k*IMP_W +: IMP_W]),
                    16'(calibrated_reference[k*IMP_W +: IMP_W]));
            end
            wait_upd(n);
            chk("period cycles", exp_period(ivs[i], mls[i], sps[i]), 16'(n));
        end
        i_tscc_host_model.wr(ADDR_CAL_CFG, 8'h08);
        cnt_pulse(300, 1'b1, n);
        chk("updates while disabled", 16'h0000, 16'(n));
        finish_test();
    end
endmodule : tb_top
